// ---- verilog/rapc_regs.sv ----
// right-channel analog power control register bank
`timescale 1ns/1ns
`include "rapc_consts.svh"
module rapc_regs
   import rapc_pkg::*;
(
   input wire logic clock,
   input wire logic reset,
   input wire logic clock_enable,
   input wire logic wr_strobe,
   input wire logic [7:0] wr_addr,
   input wire logic [7:0] wr_data,
   input wire logic [7:0] rd_addr,
   output logic [7:0] rd_data_reg,
   output logic rd_hit_reg,
   input wire logic [6:0] auto_ana_power,
   input wire logic [4:0] auto_drv_power,
   input wire logic detector_pin,
   output logic [6:0] ana_power_reg,
   output logic [4:0] drv_power_reg,
   output logic pump_mode_select_enable_reg,
   output logic pump_mode_select_reg,
   output logic halt_detector_power_reg,
   output logic halt_detector_quad_current_reg,
   output logic halt_detector_disable_reg,
   output logic clock_halt_detector_reg
);
   logic [7:0] right_analog_override_reg;
   logic [7:0] right_driver_power_state_reg;
   logic [7:0] right_analog_power_state_reg;
   logic [7:0] charge_pump_mode_ctrl_reg;
   logic [7:0] clock_halt_detect_ctrl_reg;
   logic [6:0] ana_ovr;
   logic [6:0] ana_state;
   logic [4:0] drv_on;
   logic [4:0] drv_state;
   rapc_wr_t wr;
   rapc_ctrl_t ctrl_next;

   // gather the seven analog controls: gain, mute, dummy mute, four circuits
   function automatic logic [6:0] ana_pick(input logic [7:0] r);
      ana_pick = {r[`RAPC_BIT_GAIN], r[`RAPC_BIT_MUTE], r[`RAPC_BIT_DMUTE],
         r[`RAPC_BIT_OFSCAL], r[`RAPC_BIT_SHORT], r[`RAPC_BIT_IMPS], r[`RAPC_BIT_IMPW]};
   endfunction : ana_pick

   // read mux of the whole bank, reserved bits return what was written
   function automatic logic [7:0] bank_read(input logic [7:0] a, input logic [7:0] ov,
      input logic [7:0] ds, input logic [7:0] as, input logic [7:0] cp,
      input logic [7:0] hd);
      case (a)
         `RAPC_OFS_OVERRIDE: bank_read = ov;
         `RAPC_OFS_DRV_STATE: bank_read = ds;
         `RAPC_OFS_ANA_STATE: bank_read = as;
         `RAPC_OFS_PUMP: bank_read = cp;
         `RAPC_OFS_HALT: bank_read = hd;
         default: bank_read = `RAPC_ZERO8;
      endcase
   endfunction : bank_read

   assign wr = '{strobe: wr_strobe, addr: wr_addr, data: wr_data};

   // override register, every bit plain read/write
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         right_analog_override_reg <= `RAPC_RST_OVERRIDE;
      end else if (clock_enable && wr.strobe && wr.addr == `RAPC_OFS_OVERRIDE) begin
         right_analog_override_reg <= wr.data;
      end
   end

   // driver power state, spare upper bits kept as storage
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         right_driver_power_state_reg <= `RAPC_RST_DRV_STATE;
      end else if (clock_enable && wr.strobe && wr.addr == `RAPC_OFS_DRV_STATE) begin
         right_driver_power_state_reg <= wr.data;
      end
   end

   // analog power state mirrors the override layout
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         right_analog_power_state_reg <= `RAPC_RST_ANA_STATE;
      end else if (clock_enable && wr.strobe && wr.addr == `RAPC_OFS_ANA_STATE) begin
         right_analog_power_state_reg <= wr.data;
      end
   end

   // charge pump mode, select bit comes up in constant current mode
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         charge_pump_mode_ctrl_reg <= `RAPC_RST_PUMP;
      end else if (clock_enable && wr.strobe && wr.addr == `RAPC_OFS_PUMP) begin
         charge_pump_mode_ctrl_reg <= wr.data;
      end
   end

   // clock halt detector control, powered and enabled out of reset
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         clock_halt_detect_ctrl_reg <= `RAPC_RST_HALT;
      end else if (clock_enable && wr.strobe && wr.addr == `RAPC_OFS_HALT) begin
         clock_halt_detect_ctrl_reg <= wr.data;
      end
   end

   // registered read port, answers one cycle after the address
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         rd_data_reg <= `RAPC_ZERO8;
         rd_hit_reg <= 1'b0;
      end else if (clock_enable) begin
         rd_data_reg <= bank_read(rd_addr, right_analog_override_reg,
            right_driver_power_state_reg, right_analog_power_state_reg,
            charge_pump_mode_ctrl_reg, clock_halt_detect_ctrl_reg);
         rd_hit_reg <= (rd_addr >= `RAPC_OFS_OVERRIDE) && (rd_addr <= `RAPC_OFS_HALT);
      end
   end

   // driver override bits live in the neighbouring bank; they are all-ones here
   // so the driver state bits in this bank always take effect
   assign ana_ovr = ana_pick(right_analog_override_reg);
   assign ana_state = ana_pick(right_analog_power_state_reg);
   assign drv_on = {`RAPC_DRV_CTRL_COUNT{1'b1}};
   assign drv_state = right_driver_power_state_reg[`RAPC_DRV_CTRL_COUNT-1:0];

   rapc_ovr_mux #(.WIDTH(`RAPC_ANA_CTRL_COUNT)) u_ana_mux (
      .clock(clock),
      .reset(reset),
      .clock_enable(clock_enable),
      .override_bits(ana_ovr),
      .state_bits(ana_state),
      .auto_bits(auto_ana_power),
      .power_reg(ana_power_reg)
   );

   rapc_ovr_mux #(.WIDTH(`RAPC_DRV_CTRL_COUNT)) u_drv_mux (
      .clock(clock),
      .reset(reset),
      .clock_enable(clock_enable),
      .override_bits(drv_on),
      .state_bits(drv_state),
      .auto_bits(auto_drv_power),
      .power_reg(drv_power_reg)
   );

   // pump and detector control fields
   always_comb begin
      ctrl_next = '0;
      ctrl_next.pump_mode_select_enable = charge_pump_mode_ctrl_reg[`RAPC_BIT_PUMP_EN];
      ctrl_next.pump_mode_select = charge_pump_mode_ctrl_reg[`RAPC_BIT_PUMP_SEL];
      ctrl_next.halt_detector_power = clock_halt_detect_ctrl_reg[`RAPC_BIT_HALT_PWR];
      ctrl_next.halt_detector_quad_current =
         clock_halt_detect_ctrl_reg[`RAPC_BIT_HALT_QUAD];
      ctrl_next.halt_detector_disable = clock_halt_detect_ctrl_reg[`RAPC_BIT_HALT_DIS];
   end

   // outputs staged one cycle so each comes straight from a flip-flop
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         pump_mode_select_enable_reg <= 1'b0;
         pump_mode_select_reg <= 1'b1;
         halt_detector_power_reg <= 1'b1;
         halt_detector_quad_current_reg <= 1'b0;
         halt_detector_disable_reg <= 1'b0;
      end else if (clock_enable) begin
         pump_mode_select_enable_reg <= ctrl_next.pump_mode_select_enable;
         pump_mode_select_reg <= ctrl_next.pump_mode_select;
         halt_detector_power_reg <= ctrl_next.halt_detector_power;
         halt_detector_quad_current_reg <= ctrl_next.halt_detector_quad_current;
         halt_detector_disable_reg <= ctrl_next.halt_detector_disable;
      end
   end

   rapc_halt_out u_halt (
      .clock(clock),
      .reset(reset),
      .clock_enable(clock_enable),
      .detector_disable(clock_halt_detect_ctrl_reg[`RAPC_BIT_HALT_DIS]),
      .detector_pin(detector_pin),
      .halt_reg(clock_halt_detector_reg)
   );

   // a taken write lands at the edge that takes it, spare bits included
   a_ovr_write: assert property (@(posedge clock) disable iff (reset)
      (clock_enable && wr_strobe && wr_addr == `RAPC_OFS_OVERRIDE)
      |=> right_analog_override_reg == $past(wr_data))
      else $error("override write lost");
   a_drv_write: assert property (@(posedge clock) disable iff (reset)
      (clock_enable && wr_strobe && wr_addr == `RAPC_OFS_DRV_STATE)
      |=> right_driver_power_state_reg == $past(wr_data))
      else $error("driver state write lost");
   a_ana_write: assert property (@(posedge clock) disable iff (reset)
      (clock_enable && wr_strobe && wr_addr == `RAPC_OFS_ANA_STATE)
      |=> right_analog_power_state_reg == $past(wr_data))
      else $error("analog state write lost");
   a_pump_write: assert property (@(posedge clock) disable iff (reset)
      (clock_enable && wr_strobe && wr_addr == `RAPC_OFS_PUMP)
      |=> charge_pump_mode_ctrl_reg == $past(wr_data))
      else $error("pump write lost");
   a_halt_write: assert property (@(posedge clock) disable iff (reset)
      (clock_enable && wr_strobe && wr_addr == `RAPC_OFS_HALT)
      |=> clock_halt_detect_ctrl_reg == $past(wr_data))
      else $error("halt control write lost");
   a_spare_keep: assert property (@(posedge clock) disable iff (reset)
      (clock_enable && wr_strobe && wr_addr == `RAPC_OFS_DRV_STATE)
      |=> right_driver_power_state_reg[7:5] == $past(wr_data[7:5]))
      else $error("spare bits not stored");
   a_spare_four: assert property (@(posedge clock) disable iff (reset)
      (clock_enable && wr_strobe && wr_addr == `RAPC_OFS_OVERRIDE)
      |=> right_analog_override_reg[4] == $past(wr_data[4]))
      else $error("spare override bit lost");

   // without a taken write, a frozen clock included, every register keeps its value
   a_ovr_hold: assert property (@(posedge clock) disable iff (reset)
      !(clock_enable && wr_strobe && wr_addr == `RAPC_OFS_OVERRIDE)
      |=> $stable(right_analog_override_reg))
      else $error("override changed without write");
   a_drv_hold: assert property (@(posedge clock) disable iff (reset)
      !(clock_enable && wr_strobe && wr_addr == `RAPC_OFS_DRV_STATE)
      |=> $stable(right_driver_power_state_reg))
      else $error("driver state changed without write");
   a_ana_hold: assert property (@(posedge clock) disable iff (reset)
      !(clock_enable && wr_strobe && wr_addr == `RAPC_OFS_ANA_STATE)
      |=> $stable(right_analog_power_state_reg))
      else $error("analog state changed without write");
   a_pump_hold: assert property (@(posedge clock) disable iff (reset)
      !(clock_enable && wr_strobe && wr_addr == `RAPC_OFS_PUMP)
      |=> $stable(charge_pump_mode_ctrl_reg))
      else $error("pump control changed without write");
   a_halt_hold: assert property (@(posedge clock) disable iff (reset)
      !(clock_enable && wr_strobe && wr_addr == `RAPC_OFS_HALT)
      |=> $stable(clock_halt_detect_ctrl_reg))
      else $error("halt control changed without write");

   // the mux samples override and state at one edge and shows them at the next
   a_gain_follow: assert property (@(posedge clock) disable iff (reset)
      (clock_enable && right_analog_override_reg[`RAPC_BIT_GAIN])
      |=> ana_power_reg[6] == $past(right_analog_power_state_reg[`RAPC_BIT_GAIN]))
      else $error("gain override not followed");
   a_mute_follow: assert property (@(posedge clock) disable iff (reset)
      (clock_enable && right_analog_override_reg[`RAPC_BIT_MUTE])
      |=> ana_power_reg[5] == $past(right_analog_power_state_reg[`RAPC_BIT_MUTE]))
      else $error("mute override not followed");
   a_mute_auto: assert property (@(posedge clock) disable iff (reset)
      (!reset && clock_enable && !right_analog_override_reg[`RAPC_BIT_MUTE])
      |=> ana_power_reg[5] == $past(auto_ana_power[5]))
      else $error("mute not automatic");
   a_ofscal_follow: assert property (@(posedge clock) disable iff (reset)
      (clock_enable && right_analog_override_reg[`RAPC_BIT_OFSCAL])
      |=> ana_power_reg[3] == $past(right_analog_power_state_reg[`RAPC_BIT_OFSCAL]))
      else $error("offset cal override not followed");
   a_drv_state: assert property (@(posedge clock) disable iff (reset)
      clock_enable |=> drv_power_reg == $past(right_driver_power_state_reg[4:0]))
      else $error("driver power not from state");

   // read port; the release edge is skipped because the flops still sit in reset there
   a_read_override: assert property (@(posedge clock) disable iff (reset)
      (!reset && clock_enable && rd_addr == `RAPC_OFS_OVERRIDE)
      |=> rd_data_reg == $past(right_analog_override_reg) && rd_hit_reg)
      else $error("override readback wrong");
   a_read_drv: assert property (@(posedge clock) disable iff (reset)
      (!reset && clock_enable && rd_addr == `RAPC_OFS_DRV_STATE)
      |=> rd_data_reg == $past(right_driver_power_state_reg) && rd_hit_reg)
      else $error("driver state readback wrong");
   a_read_back: assert property (@(posedge clock) disable iff (reset)
      (!reset && clock_enable && rd_addr == `RAPC_OFS_ANA_STATE)
      |=> rd_data_reg == $past(right_analog_power_state_reg) && rd_hit_reg)
      else $error("state readback wrong");
   a_read_pump: assert property (@(posedge clock) disable iff (reset)
      (!reset && clock_enable && rd_addr == `RAPC_OFS_PUMP)
      |=> rd_data_reg == $past(charge_pump_mode_ctrl_reg) && rd_hit_reg)
      else $error("pump readback wrong");
   a_read_halt: assert property (@(posedge clock) disable iff (reset)
      (!reset && clock_enable && rd_addr == `RAPC_OFS_HALT)
      |=> rd_data_reg == $past(clock_halt_detect_ctrl_reg) && rd_hit_reg)
      else $error("halt control readback wrong");
   a_unmapped_zero: assert property (@(posedge clock) disable iff (reset)
      (clock_enable && rd_addr > `RAPC_OFS_HALT) |=> rd_data_reg == `RAPC_ZERO8 && !rd_hit_reg)
      else $error("unmapped read not zero");
   a_unmapped_low: assert property (@(posedge clock) disable iff (reset)
      (clock_enable && rd_addr < `RAPC_OFS_OVERRIDE) |=> rd_data_reg == `RAPC_ZERO8 && !rd_hit_reg)
      else $error("unmapped low read not zero");

   // pump and detector fields are one-cycle copies of their register bits
   a_pump_select: assert property (@(posedge clock) disable iff (reset)
      clock_enable |=> pump_mode_select_reg == $past(charge_pump_mode_ctrl_reg[0]) &&
      pump_mode_select_enable_reg == $past(charge_pump_mode_ctrl_reg[4]))
      else $error("pump fields wrong");
   a_halt_fields: assert property (@(posedge clock) disable iff (reset)
      clock_enable |=> halt_detector_power_reg == $past(clock_halt_detect_ctrl_reg[4]) &&
      halt_detector_quad_current_reg == $past(clock_halt_detect_ctrl_reg[1]) &&
      halt_detector_disable_reg == $past(clock_halt_detect_ctrl_reg[0]))
      else $error("halt fields wrong");

   // a low clock enable must freeze the mux, read port and halt detector outputs, not just the registers
   a_freeze_all: assert property (@(posedge clock) disable iff (reset)
      !clock_enable |=> $stable(ana_power_reg) && $stable(drv_power_reg) &&
      $stable(rd_data_reg) && $stable(rd_hit_reg) && $stable(clock_halt_detector_reg))
      else $error("outputs moved while frozen");

   // main scenarios the bench should reach
   c_gain_override: cover property (@(posedge clock)
      right_analog_override_reg[`RAPC_BIT_GAIN] && right_analog_power_state_reg[7]);
   c_halt_disable: cover property (@(posedge clock)
      clock_halt_detect_ctrl_reg[`RAPC_BIT_HALT_DIS] ##1 clock_halt_detector_reg);
   c_pump_normal: cover property (@(posedge clock)
      charge_pump_mode_ctrl_reg[`RAPC_BIT_PUMP_EN] && !charge_pump_mode_ctrl_reg[0]);
   c_frozen_write: cover property (@(posedge clock)
      !clock_enable && wr_strobe);
   c_unmapped_read: cover property (@(posedge clock)
      (clock_enable && rd_addr > `RAPC_OFS_HALT) ##1 !rd_hit_reg);
endmodule : rapc_regs

// ---- verilog/rapc_consts.svh ----
// register offsets, field positions and reset values for the right analog power bank
`ifndef RAPC_CONSTS_SVH
`define RAPC_CONSTS_SVH
`define RAPC_OFS_OVERRIDE 8'h27
`define RAPC_OFS_DRV_STATE 8'h28
`define RAPC_OFS_ANA_STATE 8'h29
`define RAPC_OFS_PUMP 8'h2a
`define RAPC_OFS_HALT 8'h2b
`define RAPC_RST_OVERRIDE 8'h00
`define RAPC_RST_DRV_STATE 8'h00
`define RAPC_RST_ANA_STATE 8'h00
`define RAPC_RST_PUMP 8'h01
`define RAPC_RST_HALT 8'h10
`define RAPC_BIT_GAIN 7
`define RAPC_BIT_MUTE 6
`define RAPC_BIT_DMUTE 5
`define RAPC_BIT_OFSCAL 3
`define RAPC_BIT_SHORT 2
`define RAPC_BIT_IMPS 1
`define RAPC_BIT_IMPW 0
`define RAPC_BIT_PUMP_EN 4
`define RAPC_BIT_PUMP_SEL 0
`define RAPC_BIT_HALT_PWR 4
`define RAPC_BIT_HALT_QUAD 1
`define RAPC_BIT_HALT_DIS 0
`define RAPC_ANA_CTRL_COUNT 7
`define RAPC_DRV_CTRL_COUNT 5
`define RAPC_ZERO8 8'h00
`endif

// ---- verilog/rapc_pkg.sv ----
// types shared by the right analog power bank
package rapc_pkg;
   // register write request from the serial control port
   typedef struct packed {
      logic strobe;
      logic [7:0] addr;
      logic [7:0] data;
   } rapc_wr_t;
   // power controls delivered to the right-channel analog blocks
   typedef struct packed {
      logic [6:0] ana_power;
      logic [4:0] drv_power;
      logic pump_mode_select_enable;
      logic pump_mode_select;
      logic halt_detector_power;
      logic halt_detector_quad_current;
      logic halt_detector_disable;
   } rapc_ctrl_t;
   // bus phase state
   typedef enum logic [1:0] {
      RAPC_IDLE = 2'b01,
      RAPC_ACK = 2'b10
   } rapc_state_t;
endpackage : rapc_pkg

// ---- verilog/rapc_ovr_mux.sv ----
// per-bit selection between automatic sequencing and software state
`timescale 1ns/1ns
module rapc_ovr_mux #(
   parameter int WIDTH = 7
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic clock_enable,
   input wire logic [WIDTH-1:0] override_bits,
   input wire logic [WIDTH-1:0] state_bits,
   input wire logic [WIDTH-1:0] auto_bits,
   output logic [WIDTH-1:0] power_reg
);
   genvar i;
   // registered so the analog control lines never glitch on a bank write
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
         always_ff @(posedge clock or posedge reset) begin
            if (reset) begin
               power_reg[i] <= 1'b0;
            end else if (clock_enable) begin
               power_reg[i] <= override_bits[i] ? state_bits[i] : auto_bits[i];
            end
         end
      end
   endgenerate

   // the release edge still runs the reset branch, so attempts sampled in reset are skipped
   a_ovr_follow: assert property (@(posedge clock) disable iff (reset)
      (!reset && clock_enable) |=> power_reg == (($past(override_bits) & $past(state_bits)) |
      (~$past(override_bits) & $past(auto_bits))))
      else $error("override selection wrong");
endmodule : rapc_ovr_mux

// ---- verilog/rapc_halt_out.sv ----
// clock halt detector output conditioning
`timescale 1ns/1ns
module rapc_halt_out (
   input wire logic clock,
   input wire logic reset,
   input wire logic clock_enable,
   input wire logic detector_disable,
   input wire logic detector_pin,
   output logic halt_reg
);
   logic [2:0] sync_reg;
   // analog detector output is asynchronous: three stages, settle on agreement
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         sync_reg <= 3'h0;
      end else if (clock_enable) begin
         sync_reg <= {sync_reg[1:0], detector_pin};
      end
   end
   // held at 1 while disabled so downstream logic sees no halt event
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         halt_reg <= 1'b1;
      end else if (clock_enable) begin
         if (detector_disable) begin
            halt_reg <= 1'b1;
         end else if (sync_reg[2] == sync_reg[1]) begin
            halt_reg <= sync_reg[1];
         end
      end
   end

   a_halt_forced: assert property (@(posedge clock) disable iff (reset)
      (clock_enable && detector_disable) |=> halt_reg)
      else $error("disabled detector not forced high");
endmodule : rapc_halt_out

// ---- verification/tb_top.sv ----
// self-checking bench for the right analog power control register bank
`timescale 1ns/1ns
module tb_top;
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic clock_enable = 1'b1;
   logic wr_strobe = 1'b0;
   logic [7:0] wr_addr = 8'h00;
   logic [7:0] wr_data = 8'h00;
   logic [7:0] rd_addr = 8'h00;
   logic [6:0] auto_ana_power = 7'h00;
   logic [4:0] auto_drv_power = 5'h00;
   logic detector_pin = 1'b0;
   logic [7:0] rd_data_reg;
   logic rd_hit_reg;
   logic [6:0] ana_power_reg;
   logic [4:0] drv_power_reg;
   logic pump_en, pump_sel, halt_pwr, halt_quad, halt_dis, halt_out;
   int miscompares = 0;
   int checks = 0;
   integer seed = 87135;
   logic [7:0] mdl [0:4];
   logic [7:0] ra, rd;

   rapc_regs uut (.clock(clock), .reset(reset), .clock_enable(clock_enable),
      .wr_strobe(wr_strobe), .wr_addr(wr_addr), .wr_data(wr_data), .rd_addr(rd_addr),
      .rd_data_reg(rd_data_reg), .rd_hit_reg(rd_hit_reg), .auto_ana_power(auto_ana_power),
      .auto_drv_power(auto_drv_power), .detector_pin(detector_pin),
      .ana_power_reg(ana_power_reg), .drv_power_reg(drv_power_reg),
      .pump_mode_select_enable_reg(pump_en), .pump_mode_select_reg(pump_sel),
      .halt_detector_power_reg(halt_pwr), .halt_detector_quad_current_reg(halt_quad),
      .halt_detector_disable_reg(halt_dis), .clock_halt_detector_reg(halt_out));

   // 50 MHz clock
   always #10 clock = ~clock;

   // one comparison of any observed value against its expectation
   task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk_val

   task automatic complete_run();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : complete_run

   // reset contents of the five registers, offsets 0x27..0x2b
   task automatic model_reset();
      mdl[0] = 8'h00;
      mdl[1] = 8'h00;
      mdl[2] = 8'h00;
      mdl[3] = 8'h01;
      mdl[4] = 8'h10;
   endtask : model_reset

   // strobe is lowered at the edge that takes it, so the next call never collides
   task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      wr_strobe <= 1'b1;
      wr_addr <= a;
      wr_data <= d;
      @(posedge clock);
      wr_strobe <= 1'b0;
      if (a >= 8'h27 && a <= 8'h2b && clock_enable === 1'b1) begin
         mdl[a - 8'h27] = d;
      end
   endtask : reg_write

   task automatic reg_read(input logic [7:0] a);
      logic hit;
      logic [7:0] exp;
      hit = (a >= 8'h27 && a <= 8'h2b);
      exp = hit ? mdl[a - 8'h27] : 8'h00;
      @(posedge clock);
      rd_addr <= a;
      @(posedge clock);
      #1;
      chk_val("rd_data_reg", exp, rd_data_reg);
      chk_val("rd_hit_reg", hit, rd_hit_reg);
   endtask : reg_read

   // override set: follow the state bit; clear: follow the sequencer
   function automatic logic [6:0] exp_ana(input logic [7:0] ovr, input logic [7:0] st,
         input logic [6:0] au);
      logic [6:0] o;
      logic [6:0] s;
      o = {ovr[7:5], ovr[3:0]};
      s = {st[7:5], st[3:0]};
      return (o & s) | (~o & au);
   endfunction : exp_ana

   // derived outputs settle two edges after a write, so three is safe
   task automatic check_fields();
      repeat (3) @(posedge clock);
      #1;
      chk_val("ana_power", exp_ana(mdl[0], mdl[2], auto_ana_power), ana_power_reg);
      chk_val("drv_power", mdl[1][4:0], drv_power_reg);
      chk_val("pump_en", mdl[3][4], pump_en);
      chk_val("pump_sel", mdl[3][0], pump_sel);
      chk_val("halt_pwr", mdl[4][4], halt_pwr);
      chk_val("halt_quad", mdl[4][1], halt_quad);
      chk_val("halt_dis", mdl[4][0], halt_dis);
   endtask : check_fields

   // detector path takes up to four edges through its synchroniser
   task automatic det_check(input logic pin, input logic exp);
      @(posedge clock);
      detector_pin <= pin;
      repeat (6) @(posedge clock);
      #1;
      chk_val("halt_out", exp, halt_out);
   endtask : det_check

   task automatic read_all();
      for (int a = 8'h26; a <= 8'h2c; a++) begin
         reg_read(8'(a));
      end
   endtask : read_all

   // hang guard
   initial begin
      repeat (40000) @(posedge clock);
      miscompares++;
      complete_run();
   end

   initial begin
      model_reset();
      repeat (20) @(posedge clock);
      reset <= 1'b0;
      read_all();
      check_fields();
      // random traffic over mapped and neighbouring unmapped offsets
      for (int n = 0; n < 200; n++) begin
         ra = 8'h25 + 8'($random(seed) & 7);
         rd = 8'($random(seed));
         reg_write(ra, rd);
         auto_ana_power <= 7'($random(seed));
         auto_drv_power <= 5'($random(seed));
         reg_read(ra);
         if (n % 8 == 0) begin
            check_fields();
         end
      end
      // full override with opposite state and sequencer, then none, back to back
      @(posedge clock);
      wr_strobe <= 1'b1;
      wr_addr <= 8'h27;
      wr_data <= 8'hff;
      auto_ana_power <= 7'h7f;
      @(posedge clock);
      wr_addr <= 8'h29;
      wr_data <= 8'h00;
      @(posedge clock);
      wr_strobe <= 1'b0;
      mdl[0] = 8'hff;
      mdl[2] = 8'h00;
      check_fields();
      read_all();
      reg_write(8'h27, 8'h10);
      reg_write(8'h29, 8'hff);
      auto_ana_power <= 7'h00;
      check_fields();
      reg_write(8'h28, 8'hff);
      reg_write(8'h2a, 8'hff);
      check_fields();
      // detector enabled follows the pin, disabled reads one
      reg_write(8'h2b, 8'h12);
      det_check(1'b0, 1'b0);
      det_check(1'b1, 1'b1);
      det_check(1'b0, 1'b0);
      reg_write(8'h2b, 8'h01);
      check_fields();
      det_check(1'b0, 1'b1);
      // a write while the clock enable is low must not land
      @(posedge clock);
      clock_enable <= 1'b0;
      reg_write(8'h28, 8'h5a);
      @(posedge clock);
      clock_enable <= 1'b1;
      reg_read(8'h28);
      // second reset in mid-run restores every register
      @(posedge clock);
      reset <= 1'b1;
      repeat (2) @(posedge clock);
      reset <= 1'b0;
      model_reset();
      read_all();
      check_fields();
      complete_run();
   end
endmodule : tb_top
